// >>> intc_edge_enable_regs.sv
// Purpose: Edge select and enable registers with request flags and
//          a gated CPU interrupt request, on a classic Wishbone slave.
// Assumes: Peripheral events are one-cycle pulses on clk_i; pins are
//          asynchronous and pass three flip-flops.
// Notes:   Pin edges are taken when the 2nd and 3rd stages disagree.
//
// Function
// - Edge select bits 7..5 always read as one, hold nothing.
// - Edge bit 1 is pin one, bit 0 pin zero; 0 falling, 1 rising.
// - Enable A bit 7 gates timer A overflow requests.
// - Enable A bit 5 gates all eight wakeup pin requests together.
// - Enable A bit 2 gates the asynchronous-event pin request.
// - Enable A bits 1 and 0 gate external pin one and zero.
// - Enable B bit 7 gates the direct transition request.
// - Enable B bit 6 gates the A/D conversion end request.
// - Enable B bit 3 gates timer FH compare and overflow requests.
// - Enable B bit 2 gates timer FL compare and overflow requests.
// - Enable B bit 0 gates event counter overflow requests.
// - Flags set on event, stay on accept, clear by writing zero.
// - CPU mask bit one blocks requests; taken at instruction end.
//
// Chosen here: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ns
`include "intc_regs.svh"

module intc_edge_enable_regs #(
	parameter int NWAKE = 8
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic [31:0]      wb_adr_i,
	input  wire logic [31:0]      wb_dat_i,
	input  wire logic [3:0]       wb_sel_i,
	input  wire logic             wb_we_i,
	input  wire logic             wb_cyc_i,
	input  wire logic             wb_stb_i,
	output logic      [31:0]      wb_dat_o,
	output logic                  wb_ack_o,
	output logic                  wb_err_o,
	input  wire logic             ext_int_pin_one_i,
	input  wire logic             ext_int_pin_zero_i,
	input  wire logic             async_event_int_pin_i,
	input  wire logic [NWAKE-1:0] wakeup_pin_i,
	input  wire logic             timer_a_ovf_i,
	input  wire logic             direct_transition_i,
	input  wire logic             adc_done_i,
	input  wire logic             timer_f_high_i,
	input  wire logic             timer_f_low_i,
	input  wire logic             event_counter_ovf_i,
	input  wire logic             instr_end_i,
	output logic                  cpu_irq_o,
	output logic                  irq_o
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [7:0]             ext_pin_edge_select;
	logic [7:0]             interrupt_enable_a;
	logic [7:0]             interrupt_enable_b;
	logic [7:0]             request_flags_a;
	logic [7:0]             request_flags_b;
	logic                   cpu_mask;
	logic                   wake_flag;
	logic [`INTC_NSRC-1:0]  stat;
	logic [`INTC_NSRC-1:0]  mask;
	logic [`INTC_PIN_SYNC-1:0] s_p1;
	logic [`INTC_PIN_SYNC-1:0] s_p0;
	logic [`INTC_PIN_SYNC-1:0] s_ae;
	logic [`INTC_PIN_SYNC-1:0] s_wk [NWAKE];
	intc_pkg::intc_bus_type bus_state;

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	// Access strobe and byte-lane write
	wire       req      = wb_cyc_i & wb_stb_i & (bus_state == intc_pkg::INTC_IDLE);
	wire [5:0] ofs      = {wb_adr_i[5:2], 2'b00};
	wire       hit_hi   = (wb_adr_i[31:6] == 26'h0000000);
	wire       wr       = req & wb_we_i & wb_sel_i[0] & hit_hi;
	wire [7:0] wd       = wb_dat_i[7:0];
	wire       wr_edge  = wr & (ofs == `INTC_OFS_EDGE);
	wire       wr_ena_a = wr & (ofs == `INTC_OFS_ENA_A);
	wire       wr_ena_b = wr & (ofs == `INTC_OFS_ENA_B);
	wire       wr_fa    = wr & (ofs == `INTC_OFS_FLAG_A);
	wire       wr_fb    = wr & (ofs == `INTC_OFS_FLAG_B);
	wire       wr_cpu   = wr & (ofs == `INTC_OFS_CPU);
	wire       wr_stat  = wr & (ofs == `INTC_OFS_STAT);
	wire       wr_mask  = wr & (ofs == `INTC_OFS_MASK);
	wire       mapped   = hit_hi & (ofs <= `INTC_OFS_MASK);

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	// Three stages per pin; stage 0 feeds only stage 1
	always_ff @(posedge clk_i) begin
		s_p1 <= {s_p1[1:0], ext_int_pin_one_i};
		s_p0 <= {s_p0[1:0], ext_int_pin_zero_i};
		s_ae <= {s_ae[1:0], async_event_int_pin_i};
	end

	// Wakeup pin group, one synchroniser per pin
	logic [NWAKE-1:0] wake_fall;
	genvar gi;
	generate
		for (gi = 0; gi < NWAKE; gi++) begin : g_wake
			always_ff @(posedge clk_i) begin
				s_wk[gi] <= {s_wk[gi][1:0], wakeup_pin_i[gi]};
			end
			// Wakeup pins are active low: falling edge requests
			assign wake_fall[gi] = s_wk[gi][2] & ~s_wk[gi][1];
		end
	endgenerate

	// ------------------------------------------------------------
	// Edge detection
	// ------------------------------------------------------------
	// polarity selects edge
	wire rise_p1 = ~s_p1[2] & s_p1[1];
	wire fall_p1 = s_p1[2] & ~s_p1[1];
	wire rise_p0 = ~s_p0[2] & s_p0[1];
	wire fall_p0 = s_p0[2] & ~s_p0[1];
	wire ev_p1   = ext_pin_edge_select[`INTC_B_P1] ? rise_p1 : fall_p1;
	wire ev_p0   = ext_pin_edge_select[`INTC_B_P0] ? rise_p0 : fall_p0;
	wire ev_ae   = s_ae[2] & ~s_ae[1];
	wire ev_wk   = |wake_fall;

	// Set vectors in flag register layouts
	wire [7:0] set_a = {timer_a_ovf_i, 4'h0, ev_ae, ev_p1, ev_p0};
	wire [7:0] set_b = {direct_transition_i, adc_done_i, 2'b00,
		timer_f_high_i, timer_f_low_i, 1'b0, event_counter_ovf_i};
	wire [7:0] fa_wm = `INTC_ENA_A_WMASK & ~(8'h01 << `INTC_B_WP);
	wire [7:0] fb_wm = `INTC_ENA_B_WMASK;

	wire [7:0] next_fa = set_a | (request_flags_a &
		~(wr_fa ? (fa_wm & ~wd) : 8'h00));
	wire [7:0] next_fb = set_b | (request_flags_b &
		~(wr_fb ? (fb_wm & ~wd) : 8'h00));
	wire next_wake = ev_wk | (wake_flag & ~(wr_fa & ~wd[`INTC_B_WP]));

	// ------------------------------------------------------------
	// Enable gating
	// ------------------------------------------------------------
	// timer A gate
	wire g_ta = request_flags_a[`INTC_B_TA] & interrupt_enable_a[`INTC_B_TA];
	wire g_wp = wake_flag & interrupt_enable_a[`INTC_B_WP];
	wire g_ae = request_flags_a[`INTC_B_AEP] & interrupt_enable_a[`INTC_B_AEP];
	wire g_p1 = request_flags_a[`INTC_B_P1] & interrupt_enable_a[`INTC_B_P1];
	wire g_p0 = request_flags_a[`INTC_B_P0] & interrupt_enable_a[`INTC_B_P0];
	wire g_dt = request_flags_b[`INTC_B_DT] & interrupt_enable_b[`INTC_B_DT];
	wire g_ad = request_flags_b[`INTC_B_AD] & interrupt_enable_b[`INTC_B_AD];
	wire g_fh = request_flags_b[`INTC_B_FH] & interrupt_enable_b[`INTC_B_FH];
	wire g_fl = request_flags_b[`INTC_B_FL] & interrupt_enable_b[`INTC_B_FL];
	wire g_ec = request_flags_b[`INTC_B_EC] & interrupt_enable_b[`INTC_B_EC];
	wire any_req = g_ta | g_wp | g_ae | g_p1 | g_p0 |
		g_dt | g_ad | g_fh | g_fl | g_ec;

	// Event vector for sticky status
	wire [`INTC_NSRC-1:0] ev_vec = {set_b[`INTC_B_DT], set_b[`INTC_B_AD],
		set_b[`INTC_B_FH], set_b[`INTC_B_FL], set_b[`INTC_B_EC],
		set_a[`INTC_B_TA], ev_wk, ev_ae, ev_p1, ev_p0};
	wire [`INTC_NSRC-1:0] w1c = wr_stat ? wb_dat_i[`INTC_NSRC-1:0]
		: {`INTC_NSRC{1'b0}};
	wire [`INTC_NSRC-1:0] next_stat = ev_vec | (stat & ~w1c);

	// ------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------
	// top edge bits read one
	wire [7:0] rd_edge = `INTC_EDGE_RSVD1 | ext_pin_edge_select;
	wire [7:0] rd_fa   = `INTC_FLAG_A_RSVD1 | request_flags_a;
	logic [31:0] rdata;
	always_comb begin
		rdata = 32'h00000000;
		unique case (ofs)
			`INTC_OFS_EDGE:   rdata[7:0] = rd_edge;
			`INTC_OFS_ENA_A:  rdata[7:0] = interrupt_enable_a;
			`INTC_OFS_ENA_B:  rdata[7:0] = interrupt_enable_b;
			`INTC_OFS_FLAG_A: rdata[7:0] = rd_fa;
			`INTC_OFS_FLAG_B: rdata[7:0] = request_flags_b;
			`INTC_OFS_CPU:    rdata[1:0] = {wake_flag, cpu_mask};
			`INTC_OFS_STAT:   rdata[`INTC_NSRC-1:0] = stat;
			`INTC_OFS_MASK:   rdata[`INTC_NSRC-1:0] = mask;
			default:          rdata = 32'h00000000;
		endcase
	end

	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------
	// all cleared at reset except cpu_mask, which is set
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ext_pin_edge_select <= `INTC_RST_BYTE;
			interrupt_enable_a  <= `INTC_RST_BYTE;
			interrupt_enable_b  <= `INTC_RST_BYTE;
			cpu_mask            <= `INTC_RST_CPU_MASK;
			mask                <= {`INTC_NSRC{1'b0}};
		end else begin
			if (wr_edge) ext_pin_edge_select <= wd & `INTC_EDGE_WMASK;
			if (wr_ena_a) interrupt_enable_a <= wd & `INTC_ENA_A_WMASK;
			if (wr_ena_b) interrupt_enable_b <= wd & `INTC_ENA_B_WMASK;
			if (wr_cpu) cpu_mask <= wd[0];
			if (wr_mask) mask <= wb_dat_i[`INTC_NSRC-1:0];
		end
	end

	// Flags and sticky status
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			request_flags_a <= `INTC_RST_BYTE;
			request_flags_b <= `INTC_RST_BYTE;
			wake_flag       <= 1'b0;
			stat            <= {`INTC_NSRC{1'b0}};
		end else begin
			request_flags_a <= next_fa;
			request_flags_b <= next_fb;
			wake_flag       <= next_wake;
			stat            <= next_stat;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// masked; cpu_irq_o sampled at instruction end, irq_o every cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cpu_irq_o <= 1'b0;
			irq_o     <= 1'b0;
		end else begin
			if (instr_end_i) cpu_irq_o <= any_req & ~cpu_mask;
			irq_o <= |(next_stat & mask);
		end
	end

	// Wishbone answer one cycle after the strobe
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus_state <= intc_pkg::INTC_IDLE;
			wb_ack_o  <= 1'b0;
			wb_err_o  <= 1'b0;
			wb_dat_o  <= 32'h00000000;
		end else begin
			bus_state <= req ? intc_pkg::INTC_ACK : intc_pkg::INTC_IDLE;
			wb_ack_o  <= req & mapped;
			wb_err_o  <= req & ~mapped;
			// Data only with ack, so an error answer carries zero
			wb_dat_o  <= (req & mapped) ? rdata : 32'h00000000;
		end
	end

endmodule

// >>> intc_regs.svh
// Purpose: Register offsets, bit positions and reset values of the
//          interrupt source configuration block.
// Assumes: Classic Wishbone, 32-bit words, byte addresses.
// Notes:   Definitions only.
`ifndef INTC_REGS_SVH
`define INTC_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define INTC_OFS_EDGE     6'h00
`define INTC_OFS_ENA_A    6'h04
`define INTC_OFS_ENA_B    6'h08
`define INTC_OFS_FLAG_A   6'h0c
`define INTC_OFS_FLAG_B   6'h10
`define INTC_OFS_CPU      6'h14
`define INTC_OFS_STAT     6'h18
`define INTC_OFS_MASK     6'h1c

// ----------------------------------------------------------------
// Field positions and constants
// ----------------------------------------------------------------
`define INTC_EDGE_WMASK   8'h03
`define INTC_EDGE_RSVD1   8'he0
`define INTC_ENA_A_WMASK  8'ha7
`define INTC_ENA_B_WMASK  8'hcd
`define INTC_FLAG_A_RSVD1 8'h20
`define INTC_RST_BYTE     8'h00
`define INTC_RST_CPU_MASK 1'b1
`define INTC_B_TA   7
`define INTC_B_WP   5
`define INTC_B_AEP  2
`define INTC_B_P1   1
`define INTC_B_P0   0
`define INTC_B_DT   7
`define INTC_B_AD   6
`define INTC_B_FH   3
`define INTC_B_FL   2
`define INTC_B_EC   0
`define INTC_NSRC   10
`define INTC_PIN_SYNC 3

`endif

// >>> intc_pkg.sv
// Purpose: Shared types of the interrupt source configuration block.
// Assumes: Used with intc_regs.svh.
// Notes:   Nothing is imported; refer as intc_pkg::name.
package intc_pkg;
	// Bus slave phase
	typedef enum logic {
		INTC_IDLE,
		INTC_ACK
	} intc_bus_type;
endpackage

// >>> intc_asserts.sv
// Purpose: Port assertions for the interrupt source register block.
// Assumes: Classic Wishbone slave on one clock, sync reset.
// Notes:   Bound to every instance of the block.
`timescale 1ns/1ns
module intc_asserts (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic        wb_we_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        wb_err_o,
	input wire logic        instr_end_i,
	input wire logic        cpu_irq_o,
	input wire logic        irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Request seen by an idle slave, then a one-cycle answer
	sequence s_take;
		wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	endsequence
	sequence s_answer;
		(wb_ack_o || wb_err_o) ##1 (!wb_ack_o && !wb_err_o);
	endsequence
	property p_answer;
		s_take |=> s_answer;
	endproperty
	a_answer: assert property (p_answer) else $error("bus answer wrong");
	property p_mapped;
		s_take ##0 (wb_adr_i[31:2] <= 30'h00000007) |=> wb_ack_o;
	endproperty
	a_mapped: assert property (p_mapped) else $error("no ack on register");
	property p_unmapped;
		s_take ##0 (wb_adr_i[31:2] > 30'h00000007) |=> wb_err_o && !wb_ack_o;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("no error answer");
	property p_single;
		!(wb_ack_o && wb_err_o);
	endproperty
	a_single: assert property (p_single) else $error("ack with error");
	property p_idle_dat;
		!wb_ack_o |-> wb_dat_o == 32'h0;
	endproperty
	a_idle_dat: assert property (p_idle_dat) else $error("data without ack");
	property p_edge_rsvd;
		wb_ack_o && !wb_we_i && wb_adr_i == 32'h0 |-> wb_dat_o[31:2] == 30'h38;
	endproperty
	a_edge_rsvd: assert property (p_edge_rsvd) else $error("top bits not one");
	property p_rst_quiet;
		disable iff (1'b0) rst_i |=> !cpu_irq_o && !irq_o && !wb_ack_o;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("busy in reset");
	property p_cpu_hold;
		!instr_end_i |=> $stable(cpu_irq_o);
	endproperty
	a_cpu_hold: assert property (p_cpu_hold) else $error("cpu request moved");
endmodule

bind intc_edge_enable_regs intc_asserts chk_u (
	.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_we_i(wb_we_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .instr_end_i(instr_end_i),
	.cpu_irq_o(cpu_irq_o), .irq_o(irq_o)
);

// >>> intc_src.sv
// Purpose: Request sources standing beside the interrupt block.
// Assumes: fire_i strobes sources in status bit order.
// Notes:   Pins flip and idle high; peripherals pulse one cycle.
`timescale 1ns/1ns
module intc_src (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic [9:0] fire_i,
	output logic      [9:0] src_o
);
	localparam logic [9:0] pin_mask = 10'h00f;
	logic [9:0] next_src;
	// Pins flip on a strobe, peripheral sources follow it
	assign next_src = ((src_o ^ fire_i) & pin_mask) | (fire_i & ~pin_mask);
	// Source state, pins held high through reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			src_o <= pin_mask;
		end else begin
			src_o <= next_src;
		end
	end
endmodule

// >>> tb_top.sv
// Purpose: Self-checking bench of the interrupt source register block.
// Assumes: Classic Wishbone master, sources from intc_src.
// Notes:   Status order {dt,ad,fh,fl,ec,ta,wake,aepin,p1,p0}.
`timescale 1ns/1ns
module tb_top;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [31:0] adr = 32'h0;
	logic [31:0] wdat = 32'h0;
	logic [3:0]  sel = 4'hf;
	logic        we = 1'b0;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        ie = 1'b0;
	logic [9:0]  fire = 10'h0;
	logic [31:0] rdat;
	logic [31:0] q;
	logic        ack, err, e, cirq, irq;
	logic [9:0]  src;
	int          failures = 0;
	int          num_checks = 0;
	// Enable and flag bit of each source
	logic [7:0]  eb [10] = '{8'h01, 8'h02, 8'h04, 8'h20, 8'h80,
	                         8'h01, 8'h04, 8'h08, 8'h40, 8'h80};
	logic [5:0]  ofs [4] = '{6'h00, 6'h04, 6'h08, 6'h14};
	// Clock
	always #10 clk_i = ~clk_i;
	intc_src src_u (.clk_i(clk_i), .rst_i(rst_i), .fire_i(fire), .src_o(src));
	intc_edge_enable_regs #(.NWAKE(8)) dut_u (
		.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
		.wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
		.ext_int_pin_one_i(src[1]), .ext_int_pin_zero_i(src[0]),
		.async_event_int_pin_i(src[2]), .wakeup_pin_i({8{src[3]}}),
		.timer_a_ovf_i(src[4]), .direct_transition_i(src[9]),
		.adc_done_i(src[8]), .timer_f_high_i(src[7]),
		.timer_f_low_i(src[6]), .event_counter_ovf_i(src[5]),
		.instr_end_i(ie), .cpu_irq_o(cirq), .irq_o(irq)
	);
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One classic cycle, held until ack or err
	task automatic wb(input logic [5:0] a, input logic w, input logic [9:0] d);
		@(posedge clk_i);
		adr <= {26'h0, a};
		we <= w;
		wdat <= {22'h0, d};
		cyc <= 1'b1;
		stb <= 1'b1;
		// Only the watchdog ends a wait that never gets an answer
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1 && err !== 1'b1);
		q = rdat;
		e = err;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic tick();
		@(posedge clk_i);
		ie <= 1'b1;
		@(posedge clk_i);
		ie <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic pulse(input int s);
		@(posedge clk_i);
		fire <= 10'h1 << s;
		@(posedge clk_i);
		fire <= 10'h0;
		repeat (6) @(posedge clk_i);
	endtask
	// Values after reset
	task automatic t_reset();
		for (int i = 0; i < 4; i++) begin
			wb(ofs[i], 1'b0, 10'h0);
			chk("reset value", q, (i == 0) ? 32'he0 : {31'h0, i == 3});
		end
	endtask
	// Writable bits, ignored byte lane, unmapped place
	task automatic t_regs();
		wb(6'h00, 1'b1, 10'h003);
		wb(6'h04, 1'b1, 10'h0a7);
		wb(6'h08, 1'b1, 10'h0cd);
		sel <= 4'he;
		wb(6'h04, 1'b1, 10'h000);
		sel <= 4'hf;
		for (int i = 0; i < 3; i++) begin
			wb(ofs[i], 1'b0, 10'h0);
			chk("readback", q, (i == 0) ? 32'he3 : (i == 1) ? 32'ha7 : 32'hcd);
			wb(ofs[i], 1'b1, 10'h0);
		end
		wb(6'h20, 1'b0, 10'h0);
		chk("unmapped", e, 1'b1);
	endtask
	// Each source blocked, passed, held and cleared
	task automatic t_src();
		logic [5:0] a;
		wb(6'h14, 1'b1, 10'h0);
		wb(6'h1c, 1'b1, 10'h3ff);
		for (int s = 0; s < 10; s++) begin
			a = (s < 5) ? 6'h04 : 6'h08;
			pulse(s);
			tick();
			chk("gated", cirq, 1'b0);
			wb(a, 1'b1, {2'h0, eb[s]});
			tick();
			chk("passed", cirq, 1'b1);
			wb(a + 6'h08, 1'b0, 10'h0);
			chk("flag", q, {24'h0, eb[s] | ((s < 5) ? 8'h20 : 8'h00)});
			wb(6'h18, 1'b0, 10'h0);
			chk("status", q, 32'h1 << s);
			chk("irq", irq, 1'b1);
			wb(6'h18, 1'b1, 10'h1 << s);
			wb(a + 6'h08, 1'b1, {2'h0, ~eb[s]});
			tick();
			chk("cleared", {cirq, irq}, 2'b00);
			wb(a, 1'b1, 10'h0);
		end
	endtask
	// Status mask and cpu mask
	task automatic t_mask();
		wb(6'h1c, 1'b1, 10'h0);
		wb(6'h04, 1'b1, 10'h080);
		pulse(4);
		chk("masked irq", irq, 1'b0);
		wb(6'h1c, 1'b1, 10'h010);
		repeat (2) @(posedge clk_i);
		chk("unmasked irq", irq, 1'b1);
		wb(6'h14, 1'b1, 10'h001);
		tick();
		chk("cpu masked", cirq, 1'b0);
		wb(6'h14, 1'b1, 10'h000);
		tick();
		chk("cpu open", cirq, 1'b1);
		wb(6'h18, 1'b1, 10'h010);
		wb(6'h0c, 1'b1, 10'h07f);
		wb(6'h04, 1'b1, 10'h0);
	endtask
	// Pin edge direction per select bit, pins start low
	task automatic t_edge();
		for (int i = 0; i < 3; i++) begin
			wb(6'h00, 1'b1, (i == 2) ? 10'h002 : 10'h003);
			pulse(0);
			pulse(1);
			wb(6'h18, 1'b0, 10'h0);
			chk("edge", q, (i == 0) ? 32'h3 : (i == 1) ? 32'h0 : 32'h2);
			wb(6'h18, 1'b1, 10'h3);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_regs();
		t_src();
		t_mask();
		t_edge();
		print_verdict();
	end
	// Watchdog
	initial begin
		#200000;
		failures++;
		print_verdict();
	end
endmodule
